// [common/dab_pkg.sv]
// shared constants for the block address calculator
package dab_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [4:0] OFS_BLOCK_CONTROL = 5'h00;
  localparam logic [4:0] OFS_BEAT_COUNT    = 5'h04;
  localparam logic [4:0] OFS_SOURCE_END    = 5'h08;
  localparam logic [4:0] OFS_DEST_END      = 5'h0c;
  localparam logic [4:0] OFS_TABLE_BASE    = 5'h10;
  localparam logic [4:0] OFS_WRITEBACK     = 5'h14;
  localparam logic [4:0] OFS_NEXT_DESC     = 5'h18;
  localparam logic [4:0] OFS_COMMAND       = 5'h1c;

  // ****************************************
  // block control field positions
  // ****************************************
  localparam int BIT_SRC_INC    = 0;
  localparam int BIT_DST_INC    = 1;
  localparam int BIT_STRIDE_SEL = 2;
  localparam int POS_BEAT_CODE  = 3;
  localparam int POS_STRIDE_EXP = 5;
  localparam int CODE_W         = 2;
  localparam int EXP_W          = 3;

  // ****************************************
  // command / status field positions
  // ****************************************
  localparam int BIT_START     = 0;
  localparam int BIT_BUSY      = 1;
  localparam int BIT_ALIGN_ERR = 2;
  localparam int POS_REMAIN    = 16;

  // pointers must sit on 64-bit boundaries
  localparam int ALIGN_BITS = 3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [0:0] {
    DAB_IDLE,
    DAB_RUN
  } dab_state_t;
endpackage

// [design/dab_bus_port.sv]
// avalon-mm slave front end with one wait state
`timescale 1ns/1ps
module dab_bus_port (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] rd_data_in,
  output logic             avs_waitrequest_out,
  output logic [31:0]      avs_readdata_out,
  output logic             wr_stb_out
);
  logic ack_q;
  logic req;

  // ****************************************
  // handshake
  // ****************************************
  // ack rises one cycle after the request, drops after
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_q;
  assign wr_stb_out = ack_q & avs_write_in;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read data caught with the ack, stands while acked
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_readdata_out <= dab_pkg::RST_WORD;
    end else if (avs_read_in & ~ack_q) begin
      avs_readdata_out <= rd_data_in;
    end
  end
endmodule

// [design/dab_addr_calc.sv]
// one beat address from end address and remaining offset
`timescale 1ns/1ps
module dab_addr_calc #(
  parameter int CNT_W = 16
) (
  input  wire logic [31:0]               end_addr_in,
  input  wire logic [CNT_W-1:0]          offset_in,
  input  wire logic                      inc_in,
  input  wire logic [dab_pkg::CODE_W-1:0] code_in,
  input  wire logic                      stride_in,
  input  wire logic [dab_pkg::EXP_W-1:0]  exp_in,
  output logic [31:0]                    addr_out
);
  logic [31:0] bytes;
  logic [31:0] scaled;

  initial begin
    if (CNT_W < 1 || CNT_W > 24) begin
      $error("dab_addr_calc: CNT_W out of range");
    end
  end

  // ****************************************
  // distance from the end address
  // ****************************************
  // offset times (code + 1), scaled by 2^exp when strided
  assign bytes = 32'(offset_in) * (32'(code_in) + 32'h1);
  assign scaled = stride_in ? (bytes << exp_in) : bytes;
  // fixed side reads the stored word for every beat
  assign addr_out = inc_in ? (end_addr_in - scaled)
                           : end_addr_in;
endmodule

// [design/dab_top.sv]
// block transfer address engine with avalon-mm registers
//
// What this block does
// - source end word is 32 bits and locates the block's source data
// - no source increment: every beat reads the stored source word
// - source increment: stored word is start plus count times scaled step
// - destination end word is 32 bits and locates where beats go
// - no destination increment: every beat writes the stored word
// - destination increment: stored word is start plus count times step
// - the calculation uses the beat count caught at block start
// - beat size code sets bytes per beat; step scales by code plus one
// - stride exponent multiplies step by 2^exp when selected
`timescale 1ns/1ps
module dab_top #(
  parameter int CNT_W = 16
) (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        beat_ready_in,
  output logic             beat_valid_out,
  output logic [31:0]      beat_source_address_out,
  output logic [31:0]      beat_destination_address_out,
  output logic             beat_last_out,
  output logic             block_busy_out
);
  initial begin
    if (CNT_W < 1 || CNT_W > 16) begin
      $error("dab_top: CNT_W must be 1 to 16");
    end
  end

  // ****************************************
  // byte lane merge
  // ****************************************
  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // pointer low bits must be clear for 64-bit alignment
  function automatic logic misaligned(input logic [31:0] p);
    return |p[dab_pkg::ALIGN_BITS-1:0];
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  logic [31:0]      block_control_q;
  logic [31:0]      beat_count_q;
  logic [31:0]      source_end_address_q;
  logic [31:0]      destination_end_address_q;
  logic [31:0]      descriptor_table_base_q;
  logic [31:0]      writeback_table_base_q;
  logic [31:0]      next_descriptor_pointer_q;
  logic [31:0]      rd_mux;
  logic             wr_stb;
  logic             start;
  logic             align_err;
  dab_pkg::dab_state_t state_q;
  dab_pkg::dab_state_t state_d;
  logic [CNT_W-1:0] remain_q;
  logic [31:0]      src_end_q;
  logic [31:0]      dst_end_q;
  logic             src_inc_q;
  logic             dst_inc_q;
  logic             stride_sel_q;
  logic [dab_pkg::CODE_W-1:0] code_q;
  logic [dab_pkg::EXP_W-1:0]  exp_q;
  logic             advance;
  logic [CNT_W-1:0] offset;
  logic [31:0]      src_addr;
  logic [31:0]      dst_addr;

  // ****************************************
  // bus slave
  // ****************************************
  dab_bus_port u_bus (
    .clk_in              (clk_in),
    .arst_n_in           (arst_n_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .rd_data_in          (rd_mux),
    .avs_waitrequest_out (avs_waitrequest_out),
    .avs_readdata_out    (avs_readdata_out),
    .wr_stb_out          (wr_stb)
  );

  // start command, refused while a block runs
  assign start = wr_stb
               & (avs_address_in == dab_pkg::OFS_COMMAND)
               & avs_byteenable_in[0]
               & avs_writedata_in[dab_pkg::BIT_START]
               & (state_q == dab_pkg::DAB_IDLE);

  // ****************************************
  // register writes
  // ****************************************
  // descriptor words, byte lanes honoured
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      block_control_q           <= dab_pkg::RST_WORD;
      beat_count_q              <= dab_pkg::RST_WORD;
      source_end_address_q      <= dab_pkg::RST_WORD;
      destination_end_address_q <= dab_pkg::RST_WORD;
    end else if (wr_stb) begin
      case (avs_address_in)
        dab_pkg::OFS_BLOCK_CONTROL: begin
          block_control_q <= merge(block_control_q,
                                   avs_writedata_in,
                                   avs_byteenable_in);
        end
        dab_pkg::OFS_BEAT_COUNT: begin
          beat_count_q <= merge(beat_count_q, avs_writedata_in,
                                avs_byteenable_in);
        end
        dab_pkg::OFS_SOURCE_END: begin
          source_end_address_q <= merge(source_end_address_q,
                                        avs_writedata_in,
                                        avs_byteenable_in);
        end
        dab_pkg::OFS_DEST_END: begin
          destination_end_address_q <=
            merge(destination_end_address_q, avs_writedata_in,
                  avs_byteenable_in);
        end
        default: begin
        end
      endcase
    end
  end

  // table pointers, stored as written
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      descriptor_table_base_q   <= dab_pkg::RST_WORD;
      writeback_table_base_q    <= dab_pkg::RST_WORD;
      next_descriptor_pointer_q <= dab_pkg::RST_WORD;
    end else if (wr_stb) begin
      case (avs_address_in)
        dab_pkg::OFS_TABLE_BASE: begin
          descriptor_table_base_q <= merge(descriptor_table_base_q,
                                           avs_writedata_in,
                                           avs_byteenable_in);
        end
        dab_pkg::OFS_WRITEBACK: begin
          writeback_table_base_q <= merge(writeback_table_base_q,
                                          avs_writedata_in,
                                          avs_byteenable_in);
        end
        dab_pkg::OFS_NEXT_DESC: begin
          next_descriptor_pointer_q <=
            merge(next_descriptor_pointer_q, avs_writedata_in,
                  avs_byteenable_in);
        end
        default: begin
        end
      endcase
    end
  end

  // alignment fault shown, software must keep 64-bit boundaries
  assign align_err = misaligned(descriptor_table_base_q)
                   | misaligned(writeback_table_base_q)
                   | misaligned(next_descriptor_pointer_q);

  // ****************************************
  // register reads
  // ****************************************
  // unmapped offsets read zero
  always_comb begin
    rd_mux = dab_pkg::RST_WORD;
    case (avs_address_in)
      dab_pkg::OFS_BLOCK_CONTROL: rd_mux = block_control_q;
      dab_pkg::OFS_BEAT_COUNT:    rd_mux = beat_count_q;
      dab_pkg::OFS_SOURCE_END:    rd_mux = source_end_address_q;
      dab_pkg::OFS_DEST_END:      rd_mux = destination_end_address_q;
      dab_pkg::OFS_TABLE_BASE:    rd_mux = descriptor_table_base_q;
      dab_pkg::OFS_WRITEBACK:     rd_mux = writeback_table_base_q;
      dab_pkg::OFS_NEXT_DESC:     rd_mux = next_descriptor_pointer_q;
      dab_pkg::OFS_COMMAND: begin
        rd_mux[dab_pkg::BIT_BUSY]      = (state_q == dab_pkg::DAB_RUN);
        rd_mux[dab_pkg::BIT_ALIGN_ERR] = align_err;
        rd_mux[dab_pkg::POS_REMAIN +: CNT_W] = remain_q;
      end
      default: rd_mux = dab_pkg::RST_WORD;
    endcase
  end

  // ****************************************
  // block snapshot
  // ****************************************
  // setup frozen at start so later writes cannot disturb the block
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      src_end_q    <= dab_pkg::RST_WORD;
      dst_end_q    <= dab_pkg::RST_WORD;
      src_inc_q    <= 1'b0;
      dst_inc_q    <= 1'b0;
      stride_sel_q <= 1'b0;
      code_q       <= '0;
      exp_q        <= '0;
    end else if (start) begin
      src_end_q    <= source_end_address_q;
      dst_end_q    <= destination_end_address_q;
      src_inc_q    <= block_control_q[dab_pkg::BIT_SRC_INC];
      dst_inc_q    <= block_control_q[dab_pkg::BIT_DST_INC];
      stride_sel_q <= block_control_q[dab_pkg::BIT_STRIDE_SEL];
      code_q <= block_control_q[dab_pkg::POS_BEAT_CODE +: dab_pkg::CODE_W];
      exp_q  <= block_control_q[dab_pkg::POS_STRIDE_EXP +: dab_pkg::EXP_W];
    end
  end

  // ****************************************
  // beat sequencer
  // ****************************************
  // a new beat loads when none is held or the held one is taken
  assign advance = (state_q == dab_pkg::DAB_RUN)
                 & (~beat_valid_out | beat_ready_in);
  // count left once the beat being loaded is out
  assign offset = remain_q - CNT_W'(1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      dab_pkg::DAB_IDLE: begin
        if (start) begin
          state_d = dab_pkg::DAB_RUN;
        end
      end
      dab_pkg::DAB_RUN: begin
        if (advance && remain_q == '0) begin
          state_d = dab_pkg::DAB_IDLE;
        end
      end
      default: state_d = dab_pkg::DAB_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= dab_pkg::DAB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // initial count caught once, only decremented per beat
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      remain_q <= '0;
    end else if (start) begin
      remain_q <= beat_count_q[CNT_W-1:0];
    end else if (advance && remain_q != '0) begin
      remain_q <= offset;
    end
  end

  // ****************************************
  // address calculators
  // ****************************************
  // beat sits remain steps below the end word, so the first beat
  // is the start address and the end word is one step past the last
  dab_addr_calc #(.CNT_W(CNT_W)) u_src (
    .end_addr_in (src_end_q),
    .offset_in   (remain_q),
    .inc_in      (src_inc_q),
    .code_in     (code_q),
    .stride_in   (stride_sel_q),
    .exp_in      (exp_q),
    .addr_out    (src_addr)
  );

  dab_addr_calc #(.CNT_W(CNT_W)) u_dst (
    .end_addr_in (dst_end_q),
    .offset_in   (remain_q),
    .inc_in      (dst_inc_q),
    .code_in     (code_q),
    .stride_in   (stride_sel_q),
    .exp_in      (exp_q),
    .addr_out    (dst_addr)
  );

  // ****************************************
  // beat outputs
  // ****************************************
  // addresses held in flops until the beat is taken
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      beat_valid_out               <= 1'b0;
      beat_last_out                <= 1'b0;
      beat_source_address_out      <= dab_pkg::RST_WORD;
      beat_destination_address_out <= dab_pkg::RST_WORD;
    end else if (advance) begin
      beat_valid_out <= (remain_q != '0);
      beat_last_out  <= (remain_q == CNT_W'(1));
      if (remain_q != '0) begin
        beat_source_address_out      <= src_addr;
        beat_destination_address_out <= dst_addr;
      end
    end
  end

  assign block_busy_out = (state_q == dab_pkg::DAB_RUN);
endmodule

// [tb/dab_top_properties.sv]
// assertion checker for the block address engine ports
`timescale 1ns/1ps
module dab_top_properties #(
  parameter int CNT_W = 16
) (
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic [4:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        beat_ready_in,
  input wire logic        beat_valid_out,
  input wire logic [31:0] beat_source_address_out,
  input wire logic [31:0] beat_destination_address_out,
  input wire logic        beat_last_out,
  input wire logic        block_busy_out
);
  logic [31:0] ctrl_q, cnt_q, run_q, src_q, dst_q, seen_q, step;
  logic        wr_ok, go, take;

  // accepted writes, start requests and taken beats
  assign wr_ok = avs_write_in && !avs_waitrequest_out;
  assign go = wr_ok && avs_address_in == dab_pkg::OFS_COMMAND
              && avs_writedata_in[0] && !block_busy_out;
  assign take = beat_valid_out && beat_ready_in;
  assign step = (32'(ctrl_q[4:3]) + 32'h1)
                << (ctrl_q[2] ? ctrl_q[7:5] : 3'h0);

  // mirror of the settings registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q <= '0;
      cnt_q  <= '0;
      src_q  <= '0;
      dst_q  <= '0;
    end else if (wr_ok) begin
      case (avs_address_in)
        dab_pkg::OFS_BLOCK_CONTROL: ctrl_q <= avs_writedata_in;
        dab_pkg::OFS_BEAT_COUNT:    cnt_q <= avs_writedata_in;
        dab_pkg::OFS_SOURCE_END:    src_q <= avs_writedata_in;
        dab_pkg::OFS_DEST_END:      dst_q <= avs_writedata_in;
        default: ;
      endcase
    end
  end

  // beat count caught at start and beats taken since
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_q  <= '0;
      seen_q <= '0;
    end else if (go) begin
      run_q  <= 32'(cnt_q[CNT_W-1:0]);
      seen_q <= '0;
    end else if (take) begin
      seen_q <= seen_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence seq_start;
    go && cnt_q[CNT_W-1:0] != '0;
  endsequence
  sequence seq_first;
    block_busy_out ##1 beat_valid_out;
  endsequence

  a_first_beat: assert property (seq_start |=> seq_first)
    else $error("first beat not two cycles after start");
  a_beat_holds: assert property (beat_valid_out && !beat_ready_in |=>
    beat_valid_out && $stable(beat_source_address_out)
    && $stable(beat_destination_address_out) && $stable(beat_last_out))
    else $error("beat changed before taken");
  a_src_fixed: assert property (beat_valid_out && !ctrl_q[0] |->
    beat_source_address_out == src_q)
    else $error("fixed source address moved");
  a_dst_fixed: assert property (beat_valid_out && !ctrl_q[1] |->
    beat_destination_address_out == dst_q)
    else $error("fixed destination address moved");
  a_src_step: assert property (take && !beat_last_out && ctrl_q[0] |=>
    beat_valid_out && beat_source_address_out ==
    $past(beat_source_address_out) + step)
    else $error("source step wrong");
  a_dst_step: assert property (take && !beat_last_out && ctrl_q[1] |=>
    beat_valid_out && beat_destination_address_out ==
    $past(beat_destination_address_out) + step)
    else $error("destination step wrong");
  a_last_end: assert property (beat_valid_out && beat_last_out |->
    beat_source_address_out == (ctrl_q[0] ? src_q - step : src_q)
    && beat_destination_address_out == (ctrl_q[1] ? dst_q - step : dst_q))
    else $error("last beat not one step below stored end word");
  a_beat_count: assert property (take && beat_last_out |->
    seen_q == run_q - 32'h1)
    else $error("beat count differs from start count");
  a_one_wait: assert property ((avs_read_in || avs_write_in)
    && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("register access not answered in one wait");
endmodule

bind dab_top dab_top_properties #(.CNT_W(CNT_W)) i_dab_top_properties (
  .clk_in, .arst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
  .avs_waitrequest_out, .beat_ready_in, .beat_valid_out,
  .beat_source_address_out, .beat_destination_address_out,
  .beat_last_out, .block_busy_out);

// [tb/dab_beat_sink.sv]
// beat consumer model standing in for the system bus
`timescale 1ns/1ps
module dab_beat_sink (
  input  wire logic        clk_in,
  input  wire logic        slow_in,
  input  wire logic        valid_in,
  input  wire logic [31:0] src_in,
  input  wire logic [31:0] dst_in,
  input  wire logic        last_in,
  output logic             ready_out
);
  logic [1:0]  ph_q = 2'h0;
  logic [31:0] src_log[$];
  logic [31:0] dst_log[$];
  logic        last_log[$];

  // ready every cycle, or one cycle in four when stalling
  assign ready_out = !slow_in || ph_q == 2'h3;

  // log each beat at the edge it is taken
  always @(posedge clk_in) begin
    ph_q <= ph_q + 2'h1;
    if (valid_in && ready_out) begin
      src_log.push_back(src_in);
      dst_log.push_back(dst_in);
      last_log.push_back(last_in);
    end
  end
endmodule

// [tb/dab_top_tb.sv]
// self-checking bench for the block address engine
`timescale 1ns/1ps
module dab_top_tb;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic        slow = 1'b0;
  logic [31:0] rdat, src, dst, q;
  logic        wreq, valid, last, busy, ready;
  int          failures = 0;
  int          compares = 0;

  // free running clock
  always #50 clk_in = ~clk_in;

  dab_top #(.CNT_W(16)) i_dab_top (
    .clk_in, .arst_n_in, .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .beat_ready_in(ready),
    .beat_valid_out(valid), .beat_source_address_out(src),
    .beat_destination_address_out(dst), .beat_last_out(last),
    .block_busy_out(busy));

  dab_beat_sink i_dab_beat_sink (
    .clk_in, .slow_in(slow), .valid_in(valid), .src_in(src),
    .dst_in(dst), .last_in(last), .ready_out(ready));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic cmp(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low at an edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (n >= 100) begin
      failures++;
      results;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // program one block, run it and judge every beat
  task automatic run_block(input logic [7:0] ctrl, input logic [15:0] n,
      input logic [31:0] s, input logic [31:0] d, input logic mid);
    logic [31:0] step, off;
    int k;
    step = (32'(ctrl[4:3]) + 32'h1) << (ctrl[2] ? ctrl[7:5] : 3'h0);
    bus(1'b1, dab_pkg::OFS_BLOCK_CONTROL, {24'h0, ctrl});
    bus(1'b1, dab_pkg::OFS_BEAT_COUNT, {16'h0, n});
    bus(1'b1, dab_pkg::OFS_SOURCE_END, s);
    bus(1'b1, dab_pkg::OFS_DEST_END, d);
    i_dab_beat_sink.src_log.delete();
    i_dab_beat_sink.dst_log.delete();
    i_dab_beat_sink.last_log.delete();
    bus(1'b1, dab_pkg::OFS_COMMAND, 32'h1);
    if (mid) begin
      bus(1'b1, dab_pkg::OFS_BEAT_COUNT, 32'h9);
      bus(1'b0, dab_pkg::OFS_COMMAND, 32'h0);
      cmp("busy flag", 32'h2, q & 32'h2);
    end
    repeat (2) @(negedge clk_in);
    k = 0;
    while (busy !== 1'b0 && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 3000) begin
      failures++;
      results;
    end
    cmp("beats", 32'(n), 32'(i_dab_beat_sink.src_log.size()));
    for (k = 0; k < n; k++) begin
      off = 32'(n) - 32'(k);
      cmp("source", ctrl[0] ? s - off * step : s,
          i_dab_beat_sink.src_log[k]);
      cmp("dest", ctrl[1] ? d - off * step : d,
          i_dab_beat_sink.dst_log[k]);
      cmp("last", 32'(k == n - 1), 32'(i_dab_beat_sink.last_log[k]));
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // registers come up at zero and keep full words
  task automatic t_regs;
    for (int a = 0; a < 32; a += 4) begin
      bus(1'b0, 5'(a), 32'h0);
      cmp("reset value", dab_pkg::RST_WORD, q);
    end
    bus(1'b1, dab_pkg::OFS_SOURCE_END, 32'hfedc_ba98);
    bus(1'b0, dab_pkg::OFS_SOURCE_END, 32'h0);
    cmp("source end", 32'hfedc_ba98, q);
    bus(1'b1, dab_pkg::OFS_DEST_END, 32'h0123_4567);
    bus(1'b0, dab_pkg::OFS_DEST_END, 32'h0);
    cmp("dest end", 32'h0123_4567, q);
    bus(1'b0, 5'h02, 32'h0);
    cmp("unmapped", 32'h0, q);
  endtask

  // no increment: every beat on the stored words
  task automatic t_fixed;
    run_block(8'h18, 16'h3, 32'h2000_0010, 32'h4000_0020, 1'b0);
  endtask

  // every beat size code, both sides incrementing
  task automatic t_codes;
    for (int c = 0; c < 4; c++) begin
      run_block({3'h5, 2'(c), 3'b011}, 16'(2 + c), 32'h3000_0100,
                32'h5000_0200, 1'b0);
    end
  endtask

  // every stride exponent, stalling consumer, wrap below zero
  task automatic t_stride;
    for (int e = 0; e < 8; e++) begin
      slow <= e[0];
      run_block({3'(e), 2'h1, 3'b111}, 16'h3, 32'h0000_0100,
                32'h6000_0000, 1'b0);
    end
    slow <= 1'b0;
  endtask

  // count rewritten mid block, single beat and empty block
  task automatic t_count;
    slow <= 1'b1;
    run_block(8'h0b, 16'h6, 32'h7000_0040, 32'h7100_0080, 1'b1);
    slow <= 1'b0;
    run_block(8'h1b, 16'h1, 32'h7200_0000, 32'h7300_0000, 1'b0);
    run_block(8'h03, 16'h0, 32'h7400_0000, 32'h7500_0000, 1'b0);
  endtask

  // 64-bit aligned pointers pass, a 32-bit aligned one is flagged
  task automatic t_align;
    bus(1'b1, dab_pkg::OFS_TABLE_BASE, 32'h1000_0008);
    bus(1'b1, dab_pkg::OFS_NEXT_DESC, 32'h1000_0018);
    bus(1'b0, dab_pkg::OFS_COMMAND, 32'h0);
    cmp("align flag", 32'h0, q & 32'h4);
    bus(1'b1, dab_pkg::OFS_WRITEBACK, 32'h2000_0004);
    bus(1'b0, dab_pkg::OFS_COMMAND, 32'h0);
    cmp("align flag", 32'h4, q & 32'h4);
    bus(1'b0, dab_pkg::OFS_WRITEBACK, 32'h0);
    cmp("pointer", 32'h2000_0004, q);
  endtask

  // verdict and end of run
  task automatic results;
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_regs;
    t_fixed;
    t_codes;
    t_stride;
    t_count;
    t_align;
    results;
  end

  // watchdog
  initial begin
    #(100 * 20000);
    failures++;
    results;
  end
endmodule
